// ===== hw/sie_irq_ctrl.sv
`timescale 1ns/1ps
module sie_irq_ctrl #(
  parameter int PROX_CHANNELS = 2
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [sie_pkg::DATA_W-1:0] regWrData,
  output logic [sie_pkg::DATA_W-1:0] regRdData_ff,
  input wire sie_pkg::sie_prox_sample_type [PROX_CHANNELS-1:0] proxSample,
  input wire logic [PROX_CHANNELS-1:0][sie_pkg::RESULT_W-1:0] proxThreshold,
  input wire logic prox3Event,
  input wire logic cmdEvent,
  input wire sie_pkg::sie_ambient_sample_type ambientSample,
  input wire logic [sie_pkg::RESULT_W-1:0] ambientWindowLow,
  input wire logic [sie_pkg::RESULT_W-1:0] ambientWindowHigh,
  output logic intLevel_ff,
  output logic intDriveN_ff
);
  import sie_pkg::*;

  // refused at elaboration, the status map has room for two channels only
  if (PROX_CHANNELS < 1 || PROX_CHANNELS > 2) begin : g_badChannels
    $error("PROX_CHANNELS must be 1 or 2");
  end

  function automatic logic inWindow(input logic [RESULT_W-1:0] v,
                                    input logic [RESULT_W-1:0] lo,
                                    input logic [RESULT_W-1:0] hi);
    inWindow = (v >= lo) && (v <= hi);
  endfunction

  logic [DATA_W-1:0] intCfg_ff;
  logic [DATA_W-1:0] srcEnable_ff;
  logic [DATA_W-1:0] modeSelectA_ff;
  logic [FLAG_W-1:0] statusFlags_ff;
  logic [FLAG_W-1:0] nxt_statusFlags;
  logic [FLAG_W-1:0] setMask;
  logic [FLAG_W-1:0] clearMask;
  logic [PROX_CHANNELS-1:0] proxSet;
  logic [2:0] ambMode;
  logic visInside;
  logic irInside;
  logic ambSetLo;
  logic ambSetHi;
  logic pending;

  // reserved bits are masked on the way in, so they read back zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intCfg_ff <= INT_CFG_RESET;
      srcEnable_ff <= SRC_ENABLE_RESET;
      modeSelectA_ff <= MODE_SELECT_A_RESET;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_INT_CFG: intCfg_ff <= regWrData & INT_CFG_MASK;
        ADDR_SRC_ENABLE: srcEnable_ff <= regWrData & SRC_ENABLE_MASK;
        ADDR_MODE_SELECT_A: modeSelectA_ff <= regWrData & MODE_SELECT_A_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_ff <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_INT_CFG: regRdData_ff <= intCfg_ff;
        ADDR_SRC_ENABLE: regRdData_ff <= srcEnable_ff;
        ADDR_MODE_SELECT_A: regRdData_ff <= modeSelectA_ff;
        ADDR_STATUS: regRdData_ff <= {2'h0, statusFlags_ff};
        default: regRdData_ff <= 8'h00;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PROX_CHANNELS; gi++) begin : g_prox
      logic [1:0] mode;
      logic [RESULT_W-1:0] prevResult_ff;
      logic nowAbove;
      logic wasAbove;
      assign mode = modeSelectA_ff[PROX_MODE_BASE + 2 * gi +: 2];
      assign nowAbove = proxSample[gi].result > proxThreshold[gi];
      assign wasAbove = prevResult_ff > proxThreshold[gi];

      // previous result kept even while disabled, so enabling does not false-trip
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          prevResult_ff <= '0;
        end else if (proxSample[gi].done) begin
          prevResult_ff <= proxSample[gi].result;
        end
      end

      always_comb begin
        case (mode)
          PROX_MODE_EVERY: proxSet[gi] = proxSample[gi].done;
          PROX_MODE_CROSS: proxSet[gi] = proxSample[gi].done && (nowAbove != wasAbove);
          PROX_MODE_ABOVE: proxSet[gi] = proxSample[gi].done && nowAbove;
          default: proxSet[gi] = 1'b0;
        endcase
      end

      property p_proxAbove;
        @(posedge clock) disable iff (!rst_b)
        proxSample[gi].done && srcEnable_ff[PROX_BIT_BASE + gi]
          && modeSelectA_ff[PROX_MODE_BASE + 2 * gi +: 2] == PROX_MODE_ABOVE
          && proxSample[gi].result > proxThreshold[gi]
          |=> statusFlags_ff[PROX_BIT_BASE + gi];
      endproperty
      a_proxAbove: assert property (p_proxAbove) else $error("prox above missed");
    end
  endgenerate

  assign ambMode = modeSelectA_ff[AMB_MODE_LSB +: 3];
  assign visInside = inWindow(ambientSample.visible, ambientWindowLow, ambientWindowHigh);
  assign irInside = inWindow(ambientSample.infrared, ambientWindowLow, ambientWindowHigh);

  always_comb begin
    ambSetLo = 1'b0;
    ambSetHi = 1'b0;
    if (ambientSample.done) begin
      if (ambMode == AMB_MODE_EVERY) begin
        ambSetLo = 1'b1;
      end
      if (ambMode[1:0] == AMB_EXIT_VIS && !visInside) begin
        ambSetLo = 1'b1;
      end
      if (ambMode[1:0] == AMB_EXIT_IR && !irInside) begin
        ambSetLo = 1'b1;
      end
      if (ambMode[2:1] == AMB_ENTER_VIS && visInside) begin
        ambSetHi = 1'b1;
      end
      if (ambMode[2:1] == AMB_ENTER_IR && irInside) begin
        ambSetHi = 1'b1;
      end
    end
  end

  // sets are gated by enable, so a disabled source leaves mode without effect
  always_comb begin
    setMask = '0;
    setMask[CMD_BIT] = cmdEvent && srcEnable_ff[CMD_BIT];
    setMask[PROX3_BIT] = prox3Event && srcEnable_ff[PROX3_BIT];
    setMask[AMB_LO_BIT] = ambSetLo && srcEnable_ff[AMB_LO_BIT];
    setMask[AMB_HI_BIT] = ambSetHi && srcEnable_ff[AMB_HI_BIT];
    for (int i = 0; i < PROX_CHANNELS; i++) begin
      setMask[PROX_BIT_BASE + i] = proxSet[i] && srcEnable_ff[PROX_BIT_BASE + i];
    end
  end

  assign clearMask = (regWrEn && regAddr == ADDR_STATUS) ? regWrData[FLAG_W-1:0] : '0;
  // a set in the same cycle as the clear wins
  assign nxt_statusFlags = (statusFlags_ff & ~clearMask) | setMask;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      statusFlags_ff <= STATUS_RESET;
    end else begin
      statusFlags_ff <= nxt_statusFlags;
    end
  end

  assign pending = |(statusFlags_ff & srcEnable_ff[FLAG_W-1:0]);

  // open drain: level always low, only the enable moves
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      intDriveN_ff <= INT_RELEASED;
      intLevel_ff <= INT_PIN_LOW;
    end else begin
      intDriveN_ff <= !(intCfg_ff[OUTPUT_ENABLE_BIT] && pending);
      intLevel_ff <= INT_PIN_LOW;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_intLowCause;
    !intDriveN_ff |-> $past(intCfg_ff[OUTPUT_ENABLE_BIT]) && $past(pending);
  endproperty
  a_intLowCause: assert property (p_intLowCause) else $error("line low without cause");

  property p_cmdReachesLine;
    cmdEvent && srcEnable_ff[CMD_BIT] && intCfg_ff[OUTPUT_ENABLE_BIT] && !regWrEn
      |=> statusFlags_ff[CMD_BIT] ##1 !intDriveN_ff;
  endproperty
  a_cmdReachesLine: assert property (p_cmdReachesLine) else $error("command flag lost");

  property p_cmdBlocked;
    !srcEnable_ff[CMD_BIT] && !statusFlags_ff[CMD_BIT] |=> !statusFlags_ff[CMD_BIT];
  endproperty
  a_cmdBlocked: assert property (p_cmdBlocked) else $error("command flag set disabled");

  property p_prox3Gate;
    prox3Event && srcEnable_ff[PROX3_BIT] |=> statusFlags_ff[PROX3_BIT];
  endproperty
  a_prox3Gate: assert property (p_prox3Gate) else $error("prox3 flag missed");

  property p_prox1Every;
    proxSample[0].done && srcEnable_ff[PROX_BIT_BASE]
      && modeSelectA_ff[PROX_MODE_BASE +: 2] == PROX_MODE_EVERY |=> statusFlags_ff[PROX_BIT_BASE];
  endproperty
  a_prox1Every: assert property (p_prox1Every) else $error("prox1 completion missed");

  property p_prox1Blocked;
    !srcEnable_ff[PROX_BIT_BASE] && !statusFlags_ff[PROX_BIT_BASE]
      |=> !statusFlags_ff[PROX_BIT_BASE];
  endproperty
  a_prox1Blocked: assert property (p_prox1Blocked) else $error("prox1 set disabled");

  property p_prox1Cross;
    proxSample[0].done && srcEnable_ff[PROX_BIT_BASE]
      && modeSelectA_ff[PROX_MODE_BASE +: 2] == PROX_MODE_CROSS
      && proxSample[0].result > proxThreshold[0] && g_prox[0].prevResult_ff <= proxThreshold[0]
      |=> statusFlags_ff[PROX_BIT_BASE];
  endproperty
  a_prox1Cross: assert property (p_prox1Cross) else $error("prox1 crossing missed");

  property p_ambEvery;
    ambientSample.done && srcEnable_ff[AMB_LO_BIT] && ambMode == AMB_MODE_EVERY
      |=> statusFlags_ff[AMB_LO_BIT];
  endproperty
  a_ambEvery: assert property (p_ambEvery) else $error("ambient sample missed");

  property p_ambExit;
    ambientSample.done && srcEnable_ff[AMB_LO_BIT] && ambMode[1:0] == AMB_EXIT_VIS && !visInside
      |=> statusFlags_ff[AMB_LO_BIT];
  endproperty
  a_ambExit: assert property (p_ambExit) else $error("window exit missed");

  property p_ambExitIr;
    ambientSample.done && srcEnable_ff[AMB_LO_BIT] && ambMode[1:0] == AMB_EXIT_IR && !irInside
      |=> statusFlags_ff[AMB_LO_BIT];
  endproperty
  a_ambExitIr: assert property (p_ambExitIr) else $error("ir window exit missed");

  property p_lineLow;
    intCfg_ff[OUTPUT_ENABLE_BIT] && |(statusFlags_ff & srcEnable_ff[FLAG_W-1:0]) |=> !intDriveN_ff;
  endproperty
  a_lineLow: assert property (p_lineLow) else $error("line not pulled");

  property p_lineRelease;
    !intCfg_ff[OUTPUT_ENABLE_BIT] |=> intDriveN_ff;
  endproperty
  a_lineRelease: assert property (p_lineRelease) else $error("line driven while off");

  property p_ambEnter;
    ambientSample.done && srcEnable_ff[AMB_HI_BIT] && ambMode[2:1] == AMB_ENTER_VIS && visInside
      |=> statusFlags_ff[AMB_HI_BIT];
  endproperty
  a_ambEnter: assert property (p_ambEnter) else $error("window entry missed");

  property p_flagHolds;
    statusFlags_ff[AMB_LO_BIT] && !(regWrEn && regAddr == ADDR_STATUS && regWrData[AMB_LO_BIT])
      |=> statusFlags_ff[AMB_LO_BIT];
  endproperty
  a_flagHolds: assert property (p_flagHolds) else $error("flag dropped");

  property p_reservedZero;
    regRdEn && regAddr == ADDR_SRC_ENABLE |=> regRdData_ff[7:6] == 2'h0;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits nonzero");

  property p_resetZero;
    // own disable, the default one would mute it; second edge skips the time-zero race
    @(posedge clock) disable iff (1'b0)
      !rst_b ##1 !rst_b |-> srcEnable_ff == 8'h00 && modeSelectA_ff == 8'h00;
  endproperty
  a_resetZero: assert property (p_resetZero) else $error("reset value wrong");

  c_cmdIrq: cover property (cmdEvent && srcEnable_ff[CMD_BIT] ##2 !intDriveN_ff);
  c_proxCross: cover property (proxSet[0] && modeSelectA_ff[PROX_MODE_BASE +: 2] == PROX_MODE_CROSS);
  c_ambEnter: cover property (ambSetHi && srcEnable_ff[AMB_HI_BIT]);
  c_clearRace: cover property (|(setMask & clearMask));
  c_ambExitIr: cover property (ambSetLo && ambMode[1:0] == AMB_EXIT_IR);

endmodule

// ===== include/sie_pkg.sv
package sie_pkg;

  localparam int DATA_W = 8;
  localparam int RESULT_W = 16;
  localparam int FLAG_W = 6;

  localparam logic [7:0] ADDR_INT_CFG = 8'h03;
  localparam logic [7:0] ADDR_SRC_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_MODE_SELECT_A = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h21;

  localparam logic [7:0] INT_CFG_MASK = 8'h03;
  localparam logic [7:0] SRC_ENABLE_MASK = 8'h3f;
  localparam logic [7:0] MODE_SELECT_A_MASK = 8'hf7;

  localparam logic [7:0] INT_CFG_RESET = 8'h00;
  localparam logic [7:0] SRC_ENABLE_RESET = 8'h00;
  localparam logic [7:0] MODE_SELECT_A_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] STATUS_RESET = 6'h00;

  localparam int OUTPUT_ENABLE_BIT = 0;
  localparam int CLEAR_MODE_BIT = 1;

  localparam int AMB_LO_BIT = 0;
  localparam int AMB_HI_BIT = 1;
  localparam int PROX_BIT_BASE = 2;
  localparam int PROX3_BIT = 4;
  localparam int CMD_BIT = 5;

  localparam int PROX_MODE_BASE = 4;
  localparam int AMB_MODE_LSB = 0;

  localparam logic [1:0] PROX_MODE_EVERY = 2'h0;
  localparam logic [1:0] PROX_MODE_CROSS = 2'h1;
  localparam logic [1:0] PROX_MODE_ABOVE = 2'h3;

  localparam logic [2:0] AMB_MODE_EVERY = 3'h0;
  localparam logic [1:0] AMB_EXIT_VIS = 2'h1;
  localparam logic [1:0] AMB_EXIT_IR = 2'h3;
  localparam logic [1:0] AMB_ENTER_VIS = 2'h2;
  localparam logic [1:0] AMB_ENTER_IR = 2'h3;

  localparam logic INT_RELEASED = 1'b1;
  localparam logic INT_PIN_LOW = 1'b0;

  typedef struct packed {
    logic done;
    logic [RESULT_W-1:0] result;
  } sie_prox_sample_type;

  typedef struct packed {
    logic done;
    logic [RESULT_W-1:0] visible;
    logic [RESULT_W-1:0] infrared;
  } sie_ambient_sample_type;

endpackage

// ===== test/sie_host_model.sv
`timescale 1ns/1ps
module sie_host_model (
  input wire logic clock,
  input wire logic intDriveN,
  input wire logic intLevel,
  input wire logic [sie_pkg::DATA_W-1:0] regRdData,
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regAddr,
  output logic [sie_pkg::DATA_W-1:0] regWrData,
  output logic intLine
);
  import sie_pkg::*;
  // board pull-up: a released pin reads high
  assign intLine = (intDriveN === 1'b0) ? intLevel : 1'b1;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clock);
    regWrEn = 1'b0;
    // stale data flipped so nothing leans on a held value
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clock);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sie_pkg::*;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
  // ev: cmd, prox3, prox2, prox1, ambient
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] md;
    logic [4:0] ev;
    logic [15:0] pr;
    logic [15:0] vis;
    logic [15:0] ir;
    logic [5:0] st;
  } sie_row_type;
  sie_row_type rows [20] = '{
    '{8'h20, 8'h00, 5'h10, 16'd0, 16'd0, 16'd0, 6'h20}, '{8'h00, 8'h00, 5'h18, 16'd0, 16'd0, 16'd0, 6'h00},
    '{8'h10, 8'h00, 5'h08, 16'd0, 16'd0, 16'd0, 6'h10}, '{8'h0c, 8'h00, 5'h06, 16'd50, 16'd0, 16'd0, 6'h0c},
    '{8'h0c, 8'h50, 5'h06, 16'd150, 16'd0, 16'd0, 6'h0c}, '{8'h0c, 8'h50, 5'h06, 16'd160, 16'd0, 16'd0, 6'h00},
    '{8'h0c, 8'hf0, 5'h06, 16'd160, 16'd0, 16'd0, 6'h0c}, '{8'h0c, 8'hf0, 5'h06, 16'd90, 16'd0, 16'd0, 6'h00},
    '{8'h0c, 8'ha0, 5'h06, 16'd90, 16'd0, 16'd0, 6'h00}, '{8'h00, 8'hf0, 5'h06, 16'd160, 16'd0, 16'd0, 6'h00},
    '{8'h01, 8'h00, 5'h01, 16'd0, 16'd50, 16'd0, 6'h01}, '{8'h00, 8'h00, 5'h01, 16'd0, 16'd50, 16'd0, 6'h00},
    '{8'h01, 8'h01, 5'h01, 16'd0, 16'd50, 16'd0, 6'h01}, '{8'h01, 8'h01, 5'h01, 16'd0, 16'd150, 16'd0, 6'h00},
    '{8'h01, 8'h03, 5'h01, 16'd0, 16'd150, 16'd250, 6'h01}, '{8'h02, 8'h04, 5'h01, 16'd0, 16'd150, 16'd0, 6'h02},
    '{8'h02, 8'h06, 5'h01, 16'd0, 16'd50, 16'd150, 6'h02}, '{8'h02, 8'h06, 5'h01, 16'd0, 16'd150, 16'd50, 6'h00},
    '{8'h02, 8'h04, 5'h01, 16'd0, 16'd100, 16'd0, 6'h02}, '{8'h02, 8'h04, 5'h01, 16'd0, 16'd200, 16'd0, 6'h02}};
  logic clock, rst_b, regWrEn, regRdEn, prox3Event, cmdEvent, intLevel, intDriveN, intLine;
  logic [7:0] regAddr, regWrData, regRdData, d;
  sie_prox_sample_type [1:0] proxSample;
  sie_ambient_sample_type ambientSample;
  int errors = 0;
  int comparisons = 0;
  sie_irq_ctrl u_sie_irq_ctrl (.clock(clock), .rst_b(rst_b), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData_ff(regRdData),
    .proxSample(proxSample), .proxThreshold({16'd100, 16'd100}), .prox3Event(prox3Event),
    .cmdEvent(cmdEvent), .ambientSample(ambientSample), .ambientWindowLow(16'd100),
    .ambientWindowHigh(16'd200), .intLevel_ff(intLevel), .intDriveN_ff(intDriveN));
  sie_host_model u_sie_host_model (.clock(clock), .intDriveN(intDriveN), .intLevel(intLevel),
    .regRdData(regRdData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .intLine(intLine));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // single-cycle events; two more edges let flag and pin settle
  task automatic pulse(input sie_row_type r);
    @(negedge clock);
    {cmdEvent, prox3Event, proxSample[1].done, proxSample[0].done, ambientSample.done} = r.ev;
    proxSample[0].result = r.pr;
    proxSample[1].result = r.pr;
    ambientSample.visible = r.vis;
    ambientSample.infrared = r.ir;
    @(negedge clock);
    {cmdEvent, prox3Event, proxSample[1].done, proxSample[0].done, ambientSample.done} = 5'h00;
    repeat (2) @(negedge clock);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    {cmdEvent, prox3Event} = 2'b00;
    proxSample = '0;
    ambientSample = '0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    u_sie_host_model.rd(ADDR_SRC_ENABLE, d); `CHK(d, 8'h00)
    u_sie_host_model.rd(ADDR_MODE_SELECT_A, d); `CHK(d, 8'h00)
    `CHK(intDriveN, 1'b1)
    u_sie_host_model.wr(ADDR_INT_CFG, 8'h01);
    foreach (rows[i]) begin
      u_sie_host_model.wr(ADDR_STATUS, 8'h3f);
      u_sie_host_model.wr(ADDR_SRC_ENABLE, rows[i].en);
      u_sie_host_model.wr(ADDR_MODE_SELECT_A, rows[i].md);
      pulse(rows[i]);
      `CHK(intLine, (rows[i].st == 6'h00))
      u_sie_host_model.rd(ADDR_STATUS, d); `CHK(d, {2'b00, rows[i].st})
    end
    u_sie_host_model.wr(ADDR_STATUS, 8'h3f);
    u_sie_host_model.wr(ADDR_SRC_ENABLE, 8'h20);
    pulse(rows[0]);
    repeat (10) @(negedge clock);
    `CHK(intLine, 1'b0)
    u_sie_host_model.wr(ADDR_STATUS, 8'h20);
    repeat (2) @(negedge clock);
    `CHK(intLine, 1'b1)
    u_sie_host_model.wr(ADDR_INT_CFG, 8'h00);
    pulse(rows[0]);
    `CHK(intDriveN, 1'b1)
    u_sie_host_model.rd(ADDR_STATUS, d); `CHK(d, 8'h20)
    // clear and a fresh set on the same edge: the set has to survive
    fork
      u_sie_host_model.wr(ADDR_STATUS, 8'h20);
      begin
        @(negedge clock);
        cmdEvent = 1'b1;
        @(negedge clock);
        cmdEvent = 1'b0;
      end
    join
    u_sie_host_model.rd(ADDR_STATUS, d); `CHK(d, 8'h20)
    u_sie_host_model.wr(ADDR_SRC_ENABLE, 8'hff);
    u_sie_host_model.rd(ADDR_SRC_ENABLE, d); `CHK(d, 8'h3f)
    u_sie_host_model.wr(ADDR_MODE_SELECT_A, 8'hff);
    u_sie_host_model.rd(ADDR_MODE_SELECT_A, d); `CHK(d, 8'hf7)
    u_sie_host_model.wr(ADDR_INT_CFG, 8'hff);
    u_sie_host_model.rd(ADDR_INT_CFG, d); `CHK(d, 8'h03)
    `CHK(intLine, 1'b0)
    u_sie_host_model.rd(8'h10, d); `CHK(d, 8'h00)
    @(negedge clock);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    `CHK(intDriveN, 1'b1)
    u_sie_host_model.rd(ADDR_SRC_ENABLE, d); `CHK(d, 8'h00)
    final_report();
  end
endmodule
